//--- shared/ldd_pkg.sv
/*
  Constants for the display scan driver: register indices, field
  positions, reset values, scan timing and state encodings.
  Assumes an AHB-Lite bus where each register index takes one word.
*/
package ldd_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_PIN_OUTPUT_CONTROL    = 16'h008F;
  localparam logic [15:0] IDX_DISPLAY_DRIVE_CONTROL = 16'h0093;
  localparam logic [15:0] IDX_PORT1_DISPLAY_EN      = 16'h0094;
  localparam logic [15:0] IDX_PORT0_DISPLAY_EN      = 16'h009C;
  localparam logic [15:0] IDX_PORT2_DISPLAY_EN      = 16'h00A3;
  localparam logic [15:0] IDX_PORT3_DISPLAY_EN      = 16'h00B3;
  localparam logic [15:0] IDX_DRIVE_LEVEL_CONTROL   = 16'h00B4;
  localparam logic [15:0] IDX_SCAN_STATUS           = 16'h00B5;
  localparam logic [15:0] IDX_DISPLAY_MEM_FIRST     = 16'h2000;
  localparam logic [15:0] IDX_DISPLAY_MEM_LAST      = 16'h201B;

  localparam logic [7:0] REG_RESET = 8'h00;

  // display_drive_control fields
  localparam int DDC_SCAN_ENABLE = 7;
  localparam int DDC_TYPE_SELECT = 6;
  localparam int DDC_DUTY_HI     = 5;
  localparam int DDC_DUTY_LO     = 4;
  localparam int DDC_TRIM_HI     = 3;
  localparam int DDC_TRIM_LO     = 0;

  // pin_output_control fields
  localparam int POC_DIV_HI   = 3;
  localparam int POC_DIV_LO   = 2;
  localparam int POC_PIN_SEL  = 1;
  localparam int POC_BIAS_SEL = 0;

  // drive_level_control fields
  localparam int DLC_LEVEL_HI  = 1;
  localparam int DLC_LEVEL_LO  = 0;
  localparam int DLC_CLOCK_SEL = 7;

  localparam logic [1:0] DUTY_1_8 = 2'h0;
  localparam logic [1:0] DUTY_1_6 = 2'h1;
  localparam logic [1:0] DUTY_1_5 = 2'h2;
  localparam logic [1:0] DUTY_1_4 = 2'h3;

  localparam logic [1:0] DIV_100K = 2'h0;

  // 32.768 kHz source over a 64 Hz frame
  localparam int          SRC_HZ      = 32768;
  localparam int          FRAME_HZ    = 64;
  localparam logic [9:0]  FRAME_TICKS = 10'(SRC_HZ / FRAME_HZ);
  localparam int          HEAD_DIV    = 16;

  localparam int SEG_COUNT = 28;
  localparam int COM_COUNT = 8;

  typedef enum logic [1:0] {
    LDD_IDLE = 2'b01,
    LDD_SCAN = 2'b10
  } ldd_state_e;
endpackage : ldd_pkg

//--- src/ldd_scan_driver.sv
/*
  LCD/LED segment-common scan driver with its AHB-Lite register file
  and 28-byte display memory.
  Assumes single-word AHB-Lite transfers, slow source clocks that are
  synchronous levels to clk, and pads/analog that use the outputs.
*/
// Summary of operation
// [RQ1] one mode bit: 0 drives LCD, 1 drives LED, never both
// [RQ2] LCD and LED share pins and registers; mode bit interprets them
// [RQ3] scan enable bit turns common/segment scanning off or on
// [RQ4] duty 00: eight commons C0-C7, segments S4-S27
// [RQ5] duty 01: six commons C2-C7, segments S2-S27
// [RQ6] duty 10: five commons C3-C7, segments S1-S27
// [RQ7] duty 11: four commons, pin select bit picks the arrangement
// [RQ8] 1/4 duty, pin select 0: segments S0-S27, commons C4-C7
// [RQ9] 1/4 duty, pin select 1: segments S4-S27, commons C0-C3
// [RQ10] 4-bit trim sets drive level to supply times (17+trim)/32
// [RQ11] each port 0-3 pin has its own display output enable bit
// [RQ12] divider field picks 100k, 200k, 400k or 800k total resistance
// [RQ13] first 1/16 of each common period forces 100k, then selection
// [RQ14] bias bit selects 1/4 bias at 0 and 1/3 bias at 1
// [RQ15] scan clocked by internal 32 kHz or external crystal, 64 Hz frame
// [RQ16] LCD mode: common drive strength selectable among four levels
// [RQ17] LED mode: segment drive strength selectable among four levels
// [RQ18] display memory one byte per segment, bit n is common n
// [RQ19] each enabled common active in turn for an equal frame share
// [RQ20] scan off holds outputs inactive; restart from first common
`timescale 1ns/1ns
module ldd_scan_driver (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        lf_osc_clk,
  input  wire logic        xtal_clk,
  output logic [27:0]      seg_out,
  output logic [27:0]      seg_pin_mask,
  output logic [7:0]       com_out,
  output logic [7:0]       com_pin_mask,
  output logic             display_type_led,
  output logic             scan_running,
  output logic             lcd_invert_phase,
  output logic [31:0]      port_display_enable,
  output logic [3:0]       lcd_drive_voltage_trim,
  output logic [1:0]       divider_active_select,
  output logic             bias_one_third,
  output logic [1:0]       com_drive_level,
  output logic [1:0]       seg_drive_level
);
  logic [7:0]  display_drive_control;
  logic [7:0]  pin_output_control;
  logic [7:0]  drive_level_control;
  logic [7:0]  port_en [4];
  logic [7:0]  disp_mem [ldd_pkg::SEG_COUNT];

  logic        dp_write;
  logic [15:0] dp_index;
  logic        ap_take;
  logic [15:0] ap_index;

  ldd_pkg::ldd_state_e state;
  ldd_pkg::ldd_state_e next_state;

  logic        scan_enable;
  logic [1:0]  duty;
  logic        pin_sel;
  logic [2:0]  first_com;
  logic [2:0]  last_com;
  logic [9:0]  com_ticks;
  logic [27:0] seg_mask_sel;
  logic [7:0]  com_mask_sel;
  logic [2:0]  com_idx;
  logic [9:0]  tick_cnt;
  logic        src_prev;
  logic        src_now;
  logic        src_tick;
  logic [27:0] next_seg;
  logic [7:0]  rd_byte;
  logic        dp_fwd_ok;

  assign ap_take  = hsel & hready & htrans[1];
  assign ap_index = haddr[17:2];

  assign scan_enable = display_drive_control[ldd_pkg::DDC_SCAN_ENABLE];
  assign duty        = display_drive_control[ldd_pkg::DDC_DUTY_HI:
                                             ldd_pkg::DDC_DUTY_LO];
  assign pin_sel     = pin_output_control[ldd_pkg::POC_PIN_SEL];

  // bus: zero wait states, always OKAY
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_index <= 16'h0000;
    end else begin
      dp_write <= ap_take & hwrite;
      dp_index <= ap_index;
    end
  end

  // register writes take effect in the data phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      display_drive_control <= ldd_pkg::REG_RESET;
      pin_output_control    <= ldd_pkg::REG_RESET;
      drive_level_control   <= ldd_pkg::REG_RESET;
      for (int p = 0; p < 4; p++) begin
        port_en[p] <= ldd_pkg::REG_RESET;
      end
    end else if (dp_write) begin
      unique case (dp_index)
        ldd_pkg::IDX_DISPLAY_DRIVE_CONTROL:
          display_drive_control <= hwdata[7:0]; // RQ2
        ldd_pkg::IDX_PIN_OUTPUT_CONTROL:
          pin_output_control    <= hwdata[7:0];
        ldd_pkg::IDX_DRIVE_LEVEL_CONTROL:
          drive_level_control   <= hwdata[7:0];
        ldd_pkg::IDX_PORT0_DISPLAY_EN: port_en[0] <= hwdata[7:0]; // RQ11
        ldd_pkg::IDX_PORT1_DISPLAY_EN: port_en[1] <= hwdata[7:0]; // RQ11
        ldd_pkg::IDX_PORT2_DISPLAY_EN: port_en[2] <= hwdata[7:0]; // RQ11
        ldd_pkg::IDX_PORT3_DISPLAY_EN: port_en[3] <= hwdata[7:0]; // RQ11
        default: ;
      endcase
    end
  end

  // display memory, one byte per segment
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int s = 0; s < ldd_pkg::SEG_COUNT; s++) begin
        disp_mem[s] <= ldd_pkg::REG_RESET;
      end
    end else if (dp_write && dp_index >= ldd_pkg::IDX_DISPLAY_MEM_FIRST
                 && dp_index <= ldd_pkg::IDX_DISPLAY_MEM_LAST) begin
      disp_mem[5'(dp_index - ldd_pkg::IDX_DISPLAY_MEM_FIRST)]
        <= hwdata[7:0]; // RQ18
    end
  end

  // only indices that store a write may be forwarded; unmapped and
  // read-only indices must still read as their own value
  always_comb begin
    dp_fwd_ok = 1'b0;
    if (dp_index >= ldd_pkg::IDX_DISPLAY_MEM_FIRST
        && dp_index <= ldd_pkg::IDX_DISPLAY_MEM_LAST) begin
      dp_fwd_ok = 1'b1;
    end else begin
      unique case (dp_index)
        ldd_pkg::IDX_DISPLAY_DRIVE_CONTROL,
        ldd_pkg::IDX_PIN_OUTPUT_CONTROL,
        ldd_pkg::IDX_DRIVE_LEVEL_CONTROL,
        ldd_pkg::IDX_PORT0_DISPLAY_EN,
        ldd_pkg::IDX_PORT1_DISPLAY_EN,
        ldd_pkg::IDX_PORT2_DISPLAY_EN,
        ldd_pkg::IDX_PORT3_DISPLAY_EN: dp_fwd_ok = 1'b1;
        default:                       dp_fwd_ok = 1'b0;
      endcase
    end
  end

  // read data is captured at the address phase; a write still in its
  // data phase to the same index is forwarded
  always_comb begin
    rd_byte = 8'h00;
    if (dp_write && dp_fwd_ok && dp_index == ap_index) begin
      rd_byte = hwdata[7:0];
    end else if (ap_index >= ldd_pkg::IDX_DISPLAY_MEM_FIRST
                 && ap_index <= ldd_pkg::IDX_DISPLAY_MEM_LAST) begin
      rd_byte = disp_mem[5'(ap_index - ldd_pkg::IDX_DISPLAY_MEM_FIRST)];
    end else begin
      unique case (ap_index)
        ldd_pkg::IDX_DISPLAY_DRIVE_CONTROL: rd_byte = display_drive_control;
        ldd_pkg::IDX_PIN_OUTPUT_CONTROL:    rd_byte = pin_output_control;
        ldd_pkg::IDX_DRIVE_LEVEL_CONTROL:   rd_byte = drive_level_control;
        ldd_pkg::IDX_PORT0_DISPLAY_EN:      rd_byte = port_en[0];
        ldd_pkg::IDX_PORT1_DISPLAY_EN:      rd_byte = port_en[1];
        ldd_pkg::IDX_PORT2_DISPLAY_EN:      rd_byte = port_en[2];
        ldd_pkg::IDX_PORT3_DISPLAY_EN:      rd_byte = port_en[3];
        ldd_pkg::IDX_SCAN_STATUS:
          rd_byte = {3'h0, state == ldd_pkg::LDD_SCAN, 1'b0, com_idx};
        default:                            rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // common range, segment range and common period per duty
  always_comb begin
    first_com    = 3'h0;
    last_com     = 3'h7;
    com_ticks    = 10'(ldd_pkg::FRAME_TICKS / 8);
    seg_mask_sel = 28'hFFF_FFF0;
    com_mask_sel = 8'hFF;
    unique case (duty)
      ldd_pkg::DUTY_1_8: begin
        first_com    = 3'h0; // RQ4
        com_ticks    = 10'(ldd_pkg::FRAME_TICKS / 8);
        seg_mask_sel = 28'hFFF_FFF0;
        com_mask_sel = 8'hFF;
      end
      ldd_pkg::DUTY_1_6: begin
        first_com    = 3'h2; // RQ5
        com_ticks    = 10'(ldd_pkg::FRAME_TICKS / 6);
        seg_mask_sel = 28'hFFF_FFFC;
        com_mask_sel = 8'hFC;
      end
      ldd_pkg::DUTY_1_5: begin
        first_com    = 3'h3; // RQ6
        com_ticks    = 10'(ldd_pkg::FRAME_TICKS / 5);
        seg_mask_sel = 28'hFFF_FFFE;
        com_mask_sel = 8'hF8;
      end
      ldd_pkg::DUTY_1_4: begin
        com_ticks = 10'(ldd_pkg::FRAME_TICKS / 4); // RQ7
        if (pin_sel) begin
          first_com    = 3'h0; // RQ9
          last_com     = 3'h3;
          seg_mask_sel = 28'hFFF_FFF0;
          com_mask_sel = 8'h0F;
        end else begin
          first_com    = 3'h4; // RQ8
          seg_mask_sel = 28'hFFF_FFFF;
          com_mask_sel = 8'hF0;
        end
      end
    endcase
  end

  // scan source: rising edges of the selected 32 kHz clock
  always_comb begin
    if (drive_level_control[ldd_pkg::DLC_CLOCK_SEL]) begin
      src_now = xtal_clk; // RQ15
    end else begin
      src_now = lf_osc_clk; // RQ15
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_now;
    end
  end

  assign src_tick = src_now & ~src_prev;

  always_comb begin
    next_state = state;
    unique case (state)
      ldd_pkg::LDD_IDLE: if (scan_enable) next_state = ldd_pkg::LDD_SCAN;
      ldd_pkg::LDD_SCAN: if (!scan_enable) next_state = ldd_pkg::LDD_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ldd_pkg::LDD_IDLE;
    end else begin
      state <= next_state; // RQ3
    end
  end

  // common sequencer: equal slot per common, wraps over the frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      com_idx          <= 3'h0;
      tick_cnt         <= 10'h000;
      lcd_invert_phase <= 1'b0;
    end else if (state != ldd_pkg::LDD_SCAN) begin
      com_idx          <= first_com; // RQ20
      tick_cnt         <= 10'h000;
      lcd_invert_phase <= 1'b0;
    end else if (src_tick) begin
      if (tick_cnt >= com_ticks - 10'h001) begin
        tick_cnt <= 10'h000; // RQ19
        if (com_idx >= last_com || com_idx < first_com) begin
          com_idx          <= first_com;
          lcd_invert_phase <= ~lcd_invert_phase;
        end else begin
          com_idx <= com_idx + 3'h1;
        end
      end else begin
        tick_cnt <= tick_cnt + 10'h001;
      end
    end
  end

  // segment levels from memory bit of the active common
  for (genvar s = 0; s < ldd_pkg::SEG_COUNT; s++) begin : g_seg
    assign next_seg[s] = disp_mem[s][com_idx] & seg_mask_sel[s]; // RQ18
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seg_out      <= 28'h000_0000;
      com_out      <= 8'h00;
      seg_pin_mask <= 28'h000_0000;
      com_pin_mask <= 8'h00;
      scan_running <= 1'b0;
    end else if (state == ldd_pkg::LDD_SCAN) begin
      seg_out      <= next_seg; // RQ19
      com_out      <= 8'(1) << com_idx; // RQ19
      seg_pin_mask <= seg_mask_sel;
      com_pin_mask <= com_mask_sel;
      scan_running <= 1'b1;
    end else begin
      seg_out      <= 28'h000_0000; // RQ20
      com_out      <= 8'h00; // RQ20
      seg_pin_mask <= 28'h000_0000;
      com_pin_mask <= 8'h00;
      scan_running <= 1'b0;
    end
  end

  // analog and pad controls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      display_type_led       <= 1'b0;
      port_display_enable    <= 32'h0000_0000;
      lcd_drive_voltage_trim <= 4'h0;
      divider_active_select  <= ldd_pkg::DIV_100K;
      bias_one_third         <= 1'b0;
      com_drive_level        <= 2'h0;
      seg_drive_level        <= 2'h0;
    end else begin
      display_type_led <=
        display_drive_control[ldd_pkg::DDC_TYPE_SELECT]; // RQ1
      port_display_enable <=
        {port_en[3], port_en[2], port_en[1], port_en[0]}; // RQ11
      lcd_drive_voltage_trim <=
        display_drive_control[ldd_pkg::DDC_TRIM_HI:
                              ldd_pkg::DDC_TRIM_LO]; // RQ10
      if (tick_cnt < com_ticks / 10'(ldd_pkg::HEAD_DIV)) begin
        divider_active_select <= ldd_pkg::DIV_100K; // RQ13
      end else begin
        divider_active_select <=
          pin_output_control[ldd_pkg::POC_DIV_HI:
                             ldd_pkg::POC_DIV_LO]; // RQ12
      end
      bias_one_third <= pin_output_control[ldd_pkg::POC_BIAS_SEL]; // RQ14
      if (display_drive_control[ldd_pkg::DDC_TYPE_SELECT]) begin
        com_drive_level <= 2'h0;
        seg_drive_level <= drive_level_control[ldd_pkg::DLC_LEVEL_HI:
                                               ldd_pkg::DLC_LEVEL_LO]; // RQ17
      end else begin
        com_drive_level <= drive_level_control[ldd_pkg::DLC_LEVEL_HI:
                                               ldd_pkg::DLC_LEVEL_LO]; // RQ16
        seg_drive_level <= 2'h0;
      end
    end
  end
endmodule : ldd_scan_driver

//--- dv/ldd_checker.sv
/*
  Port checker for the display scan driver.
  Assumes it is bound to ldd_scan_driver and sees only its ports.
*/
`timescale 1ns/1ns
module ldd_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [27:0] seg_out,
  input wire logic [27:0] seg_pin_mask,
  input wire logic [7:0]  com_out,
  input wire logic [7:0]  com_pin_mask,
  input wire logic        display_type_led,
  input wire logic        scan_running,
  input wire logic [1:0]  divider_active_select,
  input wire logic [1:0]  com_drive_level,
  input wire logic [1:0]  seg_drive_level
);
  // segment pins that pair with each common arrangement
  function automatic logic [27:0] seg_of(input logic [7:0] cm);
    case (cm)
      8'hFC:   seg_of = 28'hFFFFFFC;
      8'hF8:   seg_of = 28'hFFFFFFE;
      8'hF0:   seg_of = 28'hFFFFFFF;
      default: seg_of = 28'hFFFFFF0;
    endcase
  endfunction : seg_of

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_bus_ready: assert property (
    rst_n && $past(rst_n) |-> hreadyout && !hresp)
    else $error("bus not ready or response not okay");
  a_com_onehot: assert property (
    com_out == 8'h00 || $onehot(com_out))
    else $error("more than one common active");
  a_com_in_mask: assert property (
    (com_out & ~com_pin_mask) == 8'h00)
    else $error("common outside its pin set");
  a_seg_in_mask: assert property (
    (seg_out & ~seg_pin_mask) == 28'h0)
    else $error("segment outside its pin set");
  a_pin_table: assert property (
    com_pin_mask != 8'h00 |-> seg_pin_mask == seg_of(com_pin_mask))
    else $error("segment pins do not match commons");
  a_idle_quiet: assert property (
    !scan_running [*2] |-> com_out == 8'h00 && seg_out == 28'h0)
    else $error("outputs active while scan is off");
  a_com_step: assert property (
    $past(com_out) != 8'h00 && com_out != 8'h00
      && com_out != $past(com_out)
    |-> com_out == ($past(com_out) << 1)
      || com_out == (com_pin_mask & (~com_pin_mask + 8'h01)))
    else $error("common order broken");
  a_div_head: assert property (
    $changed(com_out) && com_out != 8'h00
    |-> ##[0:2] divider_active_select == 2'h0)
    else $error("divider not forced low at common switch");
  a_drive_lcd: assert property (
    !display_type_led |-> seg_drive_level == 2'h0)
    else $error("segment level set in lcd mode");
  a_drive_led: assert property (
    display_type_led |-> com_drive_level == 2'h0)
    else $error("common level set in led mode");
endmodule : ldd_checker

bind ldd_scan_driver ldd_checker u_chk (
  .clk(clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
  .seg_out(seg_out), .seg_pin_mask(seg_pin_mask), .com_out(com_out),
  .com_pin_mask(com_pin_mask), .display_type_led(display_type_led),
  .scan_running(scan_running),
  .divider_active_select(divider_active_select),
  .com_drive_level(com_drive_level), .seg_drive_level(seg_drive_level)
);

//--- dv/ldd_glass_model.sv
/*
  Display glass model: measures how long each common is held.
  Assumes com_out is a registered level on clk.
*/
`timescale 1ns/1ns
module ldd_glass_model (
  input  wire logic       clk,
  input  wire logic [7:0] com_out,
  output int              slot_len
);
  logic [7:0] prev_com = 8'h00;
  int         cnt = 0;
  // slot length in clk cycles, latched when the common moves on
  always @(posedge clk) begin
    if (com_out !== prev_com) begin
      slot_len <= cnt;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
    prev_com <= com_out;
  end
endmodule : ldd_glass_model

//--- dv/lcd_led_matrix_scan_driver_tb.sv
/*
  Self-checking bench for the display scan driver.
  Assumes a source clock tick every 4 clk cycles from the bench.
*/
`timescale 1ns/1ns
module lcd_led_matrix_scan_driver_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready, hreadyout, hresp;
  logic [31:0] hrdata, pde, rd;
  logic        lf_osc_clk = 1'b0, xtal_clk = 1'b0, use_xtal = 1'b0;
  logic [27:0] seg_out, seg_pin_mask;
  logic [7:0]  com_out, com_pin_mask;
  logic        led, run, phase, bias;
  logic [3:0]  trim;
  logic [1:0]  div, com_lvl, seg_lvl;
  logic [1:0]  tdiv = 2'h0;
  int          err_count = 0, n_compared = 0, slot_len, i;
  logic [7:0]  mem [28];
  logic [7:0]  regm [6];
  logic [15:0] ridx [6] = '{ldd_pkg::IDX_PIN_OUTPUT_CONTROL,
    ldd_pkg::IDX_DISPLAY_DRIVE_CONTROL, ldd_pkg::IDX_PORT1_DISPLAY_EN,
    ldd_pkg::IDX_PORT0_DISPLAY_EN, ldd_pkg::IDX_PORT2_DISPLAY_EN,
    ldd_pkg::IDX_PORT3_DISPLAY_EN};

  assign hready = hreadyout;
  always #20 clk = ~clk;
  // only the selected source runs
  always @(posedge clk) begin
    tdiv <= tdiv + 2'h1;
    lf_osc_clk <= ~use_xtal & tdiv[1];
    xtal_clk <= use_xtal & tdiv[1];
  end

  ldd_scan_driver u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .lf_osc_clk(lf_osc_clk),
    .xtal_clk(xtal_clk), .seg_out(seg_out), .seg_pin_mask(seg_pin_mask),
    .com_out(com_out), .com_pin_mask(com_pin_mask),
    .display_type_led(led), .scan_running(run), .lcd_invert_phase(phase),
    .port_display_enable(pde), .lcd_drive_voltage_trim(trim),
    .divider_active_select(div), .bias_one_third(bias),
    .com_drive_level(com_lvl), .seg_drive_level(seg_lvl));
  ldd_glass_model u_glass (.clk(clk), .com_out(com_out),
    .slot_len(slot_len));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [15:0] idx,
                     input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wait_change();
    logic [7:0] old;
    int         n;
    old = com_out;
    n = 0;
    while (com_out === old && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n < 3000), 32'h1);
  endtask : wait_change

  task automatic scan(input int cfg);
    logic [1:0]  duty, lvl, dv;
    logic        segment_common_pin_select, ty, xs;
    logic [7:0]  cm;
    logic [27:0] sm, es;
    int          ticks, c, k, s, n;
    duty = cfg > 3 ? 2'h3 : 2'(cfg);
    segment_common_pin_select = cfg == 4;
    ty = cfg[0];
    xs = cfg[1];
    dv = 2'(cfg);
    lvl = 2'($urandom);
    use_xtal <= xs;
    cm = duty == 2'h0 ? 8'hFF : duty == 2'h1 ? 8'hFC :
         duty == 2'h2 ? 8'hF8 : segment_common_pin_select ? 8'h0F : 8'hF0;
    sm = duty == 2'h1 ? 28'hFFFFFFC : duty == 2'h2 ? 28'hFFFFFFE :
         (duty == 2'h3 && !segment_common_pin_select) ? 28'hFFFFFFF : 28'hFFFFFF0;
    ticks = duty == 2'h0 ? 64 : duty == 2'h1 ? 85 : duty == 2'h2 ? 102 : 128;
    n = $countones(cm);
    ahb(1'b1, ldd_pkg::IDX_DRIVE_LEVEL_CONTROL, {xs, 5'h00, lvl});
    ahb(1'b1, ridx[0], {4'h0, dv, segment_common_pin_select, 1'b0});
    ahb(1'b1, ridx[1], {1'b1, ty, duty, 4'h7});
    c = 0;
    while (!cm[c]) c++;
    for (k = 0; k <= n; k++) begin
      wait_change();
      repeat (48) @(negedge clk);
      chk(32'(com_out), 32'h1 << c);
      for (s = 0; s < 28; s++) es[s] = mem[s][c] & sm[s];
      chk(32'(seg_out), 32'(es));
      chk(32'(com_pin_mask), 32'(cm));
      chk(32'(seg_pin_mask), 32'(sm));
      chk(32'(div), 32'(dv));
      chk(32'({run, led, com_lvl, seg_lvl}),
          32'({1'b1, ty, ty ? 2'h0 : lvl, ty ? lvl : 2'h0}));
      chk(32'(phase), 32'(k == n));
      if (k == 0) begin
        ahb(1'b0, ldd_pkg::IDX_SCAN_STATUS, 8'h00);
        chk(rd, 32'h10 | 32'(c));
      end
      if (k > 1) chk(32'(slot_len), 32'(ticks * 4));
      do c = (c + 1) % 8; while (!cm[c]);
    end
    ahb(1'b1, ridx[1], {1'b0, ty, duty, 4'h7});
    repeat (3) @(negedge clk);
    chk(32'({run, com_out}), 32'h0);
    chk(32'(seg_out), 32'h0);
  endtask : scan

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    void'($urandom(5267));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 6; i++) begin
      ahb(1'b0, ridx[i], 8'h00);
      chk(rd, 32'h0);
    end
    ahb(1'b1, 16'h0080, 8'hA5);
    ahb(1'b0, 16'h0080, 8'h00);
    chk(rd, 32'h0);
    for (i = 0; i < 6; i++) begin
      regm[i] = 8'($urandom);
      if (i == 1) regm[i][7] = 1'b0;
      ahb(1'b1, ridx[i], regm[i]);
    end
    for (i = 0; i < 6; i++) begin
      ahb(1'b0, ridx[i], 8'h00);
      chk(rd, {24'h0, regm[i]});
    end
    chk(pde, {regm[5], regm[4], regm[2], regm[3]});
    chk(32'({trim, bias, led}),
        32'({regm[1][3:0], regm[0][0], regm[1][6]}));
    chk(32'({run, com_out}), 32'h0);
    for (i = 0; i < 28; i++) begin
      mem[i] = 8'($urandom);
      ahb(1'b1, ldd_pkg::IDX_DISPLAY_MEM_FIRST + 16'(i), mem[i]);
    end
    ahb(1'b0, ldd_pkg::IDX_DISPLAY_MEM_LAST, 8'h00);
    chk(rd, {24'h0, mem[27]});
    for (i = 0; i < 5; i++) scan(i);
    summarize();
  end
endmodule : lcd_led_matrix_scan_driver_tb
